// file: rtl/tccu_pkg.sv
package tccu_pkg;

  // ==========================================================================
  // Register offsets (byte addresses on the plain register port)
  localparam logic [7:0] OFS_VALUE_LOW    = 8'h15;
  localparam logic [7:0] OFS_VALUE_HIGH   = 8'h16;
  localparam logic [7:0] OFS_CONTROL      = 8'h17;
  localparam logic [7:0] OFS_IRQ_FLAGS    = 8'h0C;
  localparam logic [7:0] OFS_IRQ_ENABLES  = 8'h8C;
  localparam logic [7:0] OFS_PORT_DIR     = 8'h87;
  localparam logic [7:0] OFS_PORT_LATCH   = 8'h07;

  // ==========================================================================
  // Field positions and reset values
  localparam int         UNIT_IRQ_BIT     = 2;
  localparam int         PIN_BIT          = 2;
  localparam logic [7:0] IRQ_FLAGS_RESET  = 8'h00;
  localparam logic [7:0] IRQ_EN_RESET     = 8'h00;
  localparam logic [7:0] CONTROL_RESET    = 8'h00;
  localparam logic [7:0] VALUE_RESET      = 8'h00;
  localparam logic [3:0] PRESCALE_RESET   = 4'h0;
  localparam logic [5:0] PORT_DIR_RESET   = 6'h3F;
  localparam logic [5:0] PORT_LATCH_RESET = 6'h00;
  localparam logic [3:0] PRESCALE_4       = 4'h3;
  localparam logic [3:0] PRESCALE_16      = 4'hF;

  // ==========================================================================
  // Mode field encodings
  localparam logic [3:0] MODE_OFF         = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL    = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE    = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4   = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16  = 4'h7;
  localparam logic [3:0] MODE_CMP_HIGH    = 4'h8;
  localparam logic [3:0] MODE_CMP_LOW     = 4'h9;
  localparam logic [3:0] MODE_CMP_IRQ     = 4'hA;
  localparam logic [3:0] MODE_CMP_EVENT   = 4'hB;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tccu_bus_s;

  typedef enum logic [2:0] {
    TCCU_IDLE    = 3'b001,
    TCCU_CAPTURE = 3'b010,
    TCCU_COMPARE = 3'b100
  } tccu_state_e;

endpackage : tccu_pkg

// file: rtl/tccu_unit.sv
// The strobed register port was left to the implementer.
`timescale 1ns/100ps

// ============================================================================
// Behaviour
// - Capture copies the full 16-bit timer count into the value register.
// - Mode field picks falling, rising, every 4th or 16th rising edge.
// - Each capture sets flag bit 2; only software clears it.
// - A later capture overwrites an unread captured value.
// - With pin as output, a latch write changing the pin can capture.
// - Changing capture mode may set the flag spuriously.
// - Prescaler counter held at zero when off or not capturing.
// - Switching between prescale settings keeps the prescaler count.
// - Compare mode checks value register against timer on each update.
// - On match the pin is driven high, low or left, per mode.
// - A match sets the unit flag on the next clock edge.
// - Writing zero to control forces compare latch low, apart from port.
module tccu_unit #(
  parameter int COUNT_WIDTH = 16
) (
  input  wire logic                   clock,
  input  wire logic                   resetn,
  input  wire logic [7:0]             addr,
  input  wire logic [7:0]             wdata,
  input  wire logic                   wr,
  input  wire logic                   rd,
  output logic      [7:0]             rdata,
  input  wire logic [COUNT_WIDTH-1:0] timer_count,
  input  wire logic                   timer_tick,
  input  wire logic                   pin_in,
  output logic                        pin_out,
  output logic                        pin_oe,
  output logic                        irq
);

  // ==========================================================================
  // Parameter check
  // The value register is two byte registers, so no other count width fits
  if (COUNT_WIDTH != 16) begin : g_width_check
    $error("count width must be 16");
  end

  // ==========================================================================
  // Register decode
  tccu_pkg::tccu_bus_s bus;
  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  logic [7:0]  value_low;
  logic [7:0]  value_high;
  logic [7:0]  control;
  logic [7:0]  irq_flags;
  logic [7:0]  irq_enables;
  logic [5:0]  port_dir;
  logic [5:0]  port_latch;
  logic        cmp_latch;
  logic        sync_a;
  logic        sync_b;
  logic        pin_prev;
  logic [3:0]  prescale;

  wire wr_low   = bus.wr && bus.addr == tccu_pkg::OFS_VALUE_LOW;
  wire wr_high  = bus.wr && bus.addr == tccu_pkg::OFS_VALUE_HIGH;
  wire wr_ctrl  = bus.wr && bus.addr == tccu_pkg::OFS_CONTROL;
  wire wr_flags = bus.wr && bus.addr == tccu_pkg::OFS_IRQ_FLAGS;
  wire wr_en    = bus.wr && bus.addr == tccu_pkg::OFS_IRQ_ENABLES;
  wire wr_dir   = bus.wr && bus.addr == tccu_pkg::OFS_PORT_DIR;
  wire wr_latch = bus.wr && bus.addr == tccu_pkg::OFS_PORT_LATCH;

  wire [3:0] mode = control[3:0];
  wire is_capture = mode[3:2] == 2'b01;
  wire is_compare = mode[3:2] == 2'b10;
  tccu_pkg::tccu_state_e state;
  assign state = is_capture ? tccu_pkg::TCCU_CAPTURE :
                 is_compare ? tccu_pkg::TCCU_COMPARE : tccu_pkg::TCCU_IDLE;

  // ==========================================================================
  // Pin level seen by capture logic
  // As output, the pin carries the port latch outside compare mode, so a latch write is an edge
  wire pin_is_out  = !port_dir[tccu_pkg::PIN_BIT];
  wire pin_drive   = is_compare ? cmp_latch : port_latch[tccu_pkg::PIN_BIT];
  wire pin_level   = pin_is_out ? pin_drive : sync_b;
  wire rise        = pin_level && !pin_prev;
  wire fall        = !pin_level && pin_prev;

  // ==========================================================================
  // Capture event
  wire pre_wrap4   = prescale == tccu_pkg::PRESCALE_4;
  wire pre_wrap16  = prescale == tccu_pkg::PRESCALE_16;
  logic cap_event;
  always_comb begin
    unique case (mode)
      tccu_pkg::MODE_CAP_FALL:   cap_event = fall;
      tccu_pkg::MODE_CAP_RISE:   cap_event = rise;
      tccu_pkg::MODE_CAP_RISE4:  cap_event = rise && pre_wrap4;
      tccu_pkg::MODE_CAP_RISE16: cap_event = rise && pre_wrap16;
      default:                   cap_event = 1'b0;
    endcase
  end

  // Any new capture mode written while capturing counts as a possible false event
  // Turning the unit off first is the clean path, so only capture to capture flags
  wire mode_change = wr_ctrl && is_capture && bus.wdata[3:2] == 2'b01
                     && bus.wdata[3:0] != mode;

  logic [3:0] next_prescale;
  always_comb begin
    if (state != tccu_pkg::TCCU_CAPTURE) begin
      next_prescale = tccu_pkg::PRESCALE_RESET;
    end else if (cap_event) begin
      next_prescale = tccu_pkg::PRESCALE_RESET;
    end else if (rise) begin
      next_prescale = prescale + 4'h1;
    end else begin
      next_prescale = prescale;
    end
  end

  // ==========================================================================
  // Compare
  wire cmp_match = state == tccu_pkg::TCCU_COMPARE && timer_tick
                   && timer_count == {value_high, value_low};
  logic next_cmp_latch;
  always_comb begin
    next_cmp_latch = cmp_latch;
    if (cmp_match && mode == tccu_pkg::MODE_CMP_HIGH) begin
      next_cmp_latch = 1'b1;
    end
    if (cmp_match && mode == tccu_pkg::MODE_CMP_LOW) begin
      next_cmp_latch = 1'b0;
    end
    if (wr_ctrl && bus.wdata == 8'h00) begin
      next_cmp_latch = 1'b0;
    end
  end

  wire flag_set = cap_event || cmp_match || mode_change;

  // ==========================================================================
  // Registers
  always_ff @(posedge clock) begin
    if (!resetn) begin
      sync_a      <= 1'b0;
      sync_b      <= 1'b0;
      pin_prev    <= 1'b0;
      prescale    <= tccu_pkg::PRESCALE_RESET;
      control     <= tccu_pkg::CONTROL_RESET;
      cmp_latch   <= 1'b0;
      port_dir    <= tccu_pkg::PORT_DIR_RESET;
      port_latch  <= tccu_pkg::PORT_LATCH_RESET;
      irq_enables <= tccu_pkg::IRQ_EN_RESET;
    end else begin
      sync_a      <= pin_in;
      sync_b      <= sync_a;
      pin_prev    <= pin_level;
      prescale    <= next_prescale;
      cmp_latch   <= next_cmp_latch;
      if (wr_ctrl) control <= {2'b00, bus.wdata[5:0]};
      if (wr_dir) port_dir <= bus.wdata[5:0];
      if (wr_latch) port_latch <= bus.wdata[5:0];
      if (wr_en) irq_enables <= bus.wdata;
    end
  end

  // Capture beats a software write in the same cycle so no sample is lost
  always_ff @(posedge clock) begin
    if (!resetn) begin
      value_low  <= tccu_pkg::VALUE_RESET;
      value_high <= tccu_pkg::VALUE_RESET;
    end else if (cap_event) begin
      value_low  <= timer_count[7:0];
      value_high <= timer_count[15:8];
    end else begin
      if (wr_low) value_low <= bus.wdata;
      if (wr_high) value_high <= bus.wdata;
    end
  end

  // Flags clear by writing one; a set in the same cycle wins
  logic [7:0] flag_set_vec;
  always_comb begin
    flag_set_vec = 8'h00;
    flag_set_vec[tccu_pkg::UNIT_IRQ_BIT] = flag_set;
  end
  wire [7:0] flag_clr = wr_flags ? bus.wdata : 8'h00;

  always_ff @(posedge clock) begin
    if (!resetn) begin
      irq_flags <= tccu_pkg::IRQ_FLAGS_RESET;
    end else begin
      irq_flags <= (irq_flags & ~flag_clr) | flag_set_vec;
    end
  end

  // ==========================================================================
  // Outputs
  logic [7:0] read_mux;
  always_comb begin
    unique case (bus.addr)
      tccu_pkg::OFS_VALUE_LOW:   read_mux = value_low;
      tccu_pkg::OFS_VALUE_HIGH:  read_mux = value_high;
      tccu_pkg::OFS_CONTROL:     read_mux = control;
      tccu_pkg::OFS_IRQ_FLAGS:   read_mux = irq_flags;
      tccu_pkg::OFS_IRQ_ENABLES: read_mux = irq_enables;
      tccu_pkg::OFS_PORT_DIR:    read_mux = {2'b00, port_dir};
      tccu_pkg::OFS_PORT_LATCH:  read_mux = {2'b00, port_latch};
      default:                   read_mux = 8'h00;
    endcase
  end

  wire [7:0] next_flags = (irq_flags & ~flag_clr) | flag_set_vec;
  wire next_irq = |(next_flags & (wr_en ? bus.wdata : irq_enables));

  always_ff @(posedge clock) begin
    if (!resetn) begin
      rdata   <= 8'h00;
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
      irq     <= 1'b0;
    end else begin
      rdata   <= bus.rd ? read_mux : 8'h00;
      pin_out <= pin_drive;
      pin_oe  <= pin_is_out;
      irq     <= next_irq;
    end
  end

  // ==========================================================================
  // Checks
  // Capture side: the copy, the flag and the edge choice
  a_capture_copies: assert property (@(posedge clock) disable iff (!resetn)
    cap_event |=> {value_high, value_low} == $past(timer_count))
    else $error("capture did not copy timer");
  a_flag_on_capture: assert property (@(posedge clock) disable iff (!resetn)
    cap_event |=> irq_flags[tccu_pkg::UNIT_IRQ_BIT])
    else $error("capture flag not set");
  // Only a write to the flag register may take the flag down
  a_flag_sticky: assert property (@(posedge clock) disable iff (!resetn)
    irq_flags[tccu_pkg::UNIT_IRQ_BIT] && !wr_flags |=> irq_flags[tccu_pkg::UNIT_IRQ_BIT])
    else $error("flag dropped without a clear");
  a_irq_level: assert property (@(posedge clock) disable iff (!resetn)
    irq == |(irq_flags & irq_enables))
    else $error("interrupt does not follow the flags");
  a_fall_capture: assert property (@(posedge clock) disable iff (!resetn)
    mode == tccu_pkg::MODE_CAP_FALL && fall |-> cap_event)
    else $error("falling edge not captured");
  a_rise_capture: assert property (@(posedge clock) disable iff (!resetn)
    mode == tccu_pkg::MODE_CAP_RISE && rise |-> cap_event)
    else $error("rising edge not captured");
  a_rise4_count: assert property (@(posedge clock) disable iff (!resetn)
    mode == tccu_pkg::MODE_CAP_RISE4 && rise && prescale != tccu_pkg::PRESCALE_4
    |-> !cap_event)
    else $error("early capture in divide by four");
  a_rise16_count: assert property (@(posedge clock) disable iff (!resetn)
    mode == tccu_pkg::MODE_CAP_RISE16 && rise && prescale != tccu_pkg::PRESCALE_16
    |-> !cap_event)
    else $error("early capture in divide by sixteen");
  // A latch write that lifts a driven pin must look like an outside edge
  a_port_edge: assert property (@(posedge clock) disable iff (!resetn)
    mode == tccu_pkg::MODE_CAP_RISE && pin_is_out && !wr_ctrl && !wr_dir && wr_latch
    && bus.wdata[tccu_pkg::PIN_BIT] && !port_latch[tccu_pkg::PIN_BIT] |=> cap_event)
    else $error("port write did not capture");
  a_sync_path: assert property (@(posedge clock) disable iff (!resetn)
    !pin_is_out |-> pin_level == $past(pin_in, 2))
    else $error("pin not synchronised");

  // ==========================================================================
  // Checks on the prescaler and the mode switch flag
  a_prescale_zero: assert property (@(posedge clock) disable iff (!resetn)
    !is_capture |=> prescale == tccu_pkg::PRESCALE_RESET)
    else $error("prescaler not cleared");
  a_prescale_keep: assert property (@(posedge clock) disable iff (!resetn)
    mode_change && !rise && !fall |=> prescale == $past(prescale))
    else $error("prescaler lost on mode switch");
  a_spurious_flag: assert property (@(posedge clock) disable iff (!resetn)
    mode_change |=> irq_flags[tccu_pkg::UNIT_IRQ_BIT])
    else $error("mode switch flag not set");

  // ==========================================================================
  // Checks on compare
  a_compare_flag: assert property (@(posedge clock) disable iff (!resetn)
    cmp_match |=> irq_flags[tccu_pkg::UNIT_IRQ_BIT])
    else $error("compare flag not set");
  a_tick_gates_compare: assert property (@(posedge clock) disable iff (!resetn)
    is_compare && !timer_tick && !wr_ctrl |=> cmp_latch == $past(cmp_latch))
    else $error("compare acted without a timer update");
  a_compare_high: assert property (@(posedge clock) disable iff (!resetn)
    cmp_match && mode == tccu_pkg::MODE_CMP_HIGH && !wr_ctrl |=> cmp_latch)
    else $error("compare did not drive high");
  a_compare_low: assert property (@(posedge clock) disable iff (!resetn)
    cmp_match && mode == tccu_pkg::MODE_CMP_LOW && !wr_ctrl |=> !cmp_latch)
    else $error("compare did not drive low");
  a_compare_keep: assert property (@(posedge clock) disable iff (!resetn)
    cmp_match && (mode == tccu_pkg::MODE_CMP_IRQ || mode == tccu_pkg::MODE_CMP_EVENT)
    && !wr_ctrl |=> cmp_latch == $past(cmp_latch))
    else $error("flag only compare moved the pin");
  a_compare_pin: assert property (@(posedge clock) disable iff (!resetn)
    is_compare |=> pin_out == $past(cmp_latch))
    else $error("pin does not show compare latch");
  a_zero_ctrl_low: assert property (@(posedge clock) disable iff (!resetn)
    wr_ctrl && bus.wdata == 8'h00 |=> !cmp_latch)
    else $error("compare latch not forced low");
  a_latch_apart: assert property (@(posedge clock) disable iff (!resetn)
    is_compare && wr_latch && !cmp_match && !wr_ctrl |=> cmp_latch == $past(cmp_latch))
    else $error("port write moved compare latch");

endmodule : tccu_unit

// file: verification/tccu_pin_source.sv
`timescale 1ns/100ps

// ==========================================================================
// Outside source or load on the capture pin
module tccu_pin_source (
  input  wire logic ext_level,
  input  wire logic pin_out,
  input  wire logic pin_oe,
  output logic      pin_level
);
  // The device drive wins while enabled, so a latch write can make an edge
  assign pin_level = pin_oe ? pin_out : ext_level;
endmodule : tccu_pin_source

// file: verification/timer_capture_compare_unit_bench.sv
`timescale 1ns/100ps

// ==========================================================================
// Bench
module timer_capture_compare_unit_bench;
  logic        clock;
  logic        resetn;
  logic [7:0]  addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic [7:0]  rdata;
  logic [15:0] timer_count;
  logic        timer_tick;
  logic        ext_level;
  logic        pin_level;
  logic        pin_out;
  logic        pin_oe;
  logic        irq;
  logic [7:0]  got;
  int          miscompares;
  int          n_checks;

  tccu_unit dut (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .timer_count(timer_count), .timer_tick(timer_tick),
    .pin_in(pin_level), .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
  tccu_pin_source pin (.ext_level(ext_level), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_level(pin_level));

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [7:0] act, input logic [7:0] exp);
    n_checks++;
    if (act !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clock);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 got = rdata;
  endtask : rd_reg

  // Bounded so a missing capture ends the run instead of hanging it
  task automatic wait_irq;
    for (int i = 0; i < 24 && irq !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    if (irq !== 1'b1) begin
      miscompares++;
      $display("wrong value at %0t: interrupt never came", $time);
      end_of_test;
    end
  endtask : wait_irq

  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clock) ext_level <= 1'b1;
      repeat (3) @(posedge clock);
      ext_level <= 1'b0;
      repeat (3) @(posedge clock);
    end
  endtask : pulse

  task automatic capture_cycle(input logic [3:0] m, input logic [15:0] t, input int n);
    wr_reg(tccu_pkg::OFS_CONTROL, 8'h00);
    wr_reg(tccu_pkg::OFS_CONTROL, {4'h0, m});
    wr_reg(tccu_pkg::OFS_IRQ_FLAGS, 8'h04);
    timer_count <= t;
    pulse(n - 1);
    repeat (4) @(posedge clock);
    #1 check(8'(irq), 8'h00);
    pulse(1);
    wait_irq;
    rd_reg(tccu_pkg::OFS_VALUE_LOW);
    check(got, t[7:0]);
    rd_reg(tccu_pkg::OFS_VALUE_HIGH);
    check(got, t[15:8]);
  endtask : capture_cycle

  task automatic flag_clear;
    rd_reg(tccu_pkg::OFS_IRQ_FLAGS);
    check(got, 8'h04);
    wr_reg(tccu_pkg::OFS_IRQ_FLAGS, 8'h04);
    rd_reg(tccu_pkg::OFS_IRQ_FLAGS);
    check(got, 8'h00);
    check(8'(irq), 8'h00);
  endtask : flag_clear

  task automatic overwrite_and_port;
    capture_cycle(tccu_pkg::MODE_CAP_FALL, 16'h0F1E, 1);
    wr_reg(tccu_pkg::OFS_IRQ_FLAGS, 8'h04);
    timer_count <= 16'hE1F0;
    pulse(1);
    wait_irq;
    rd_reg(tccu_pkg::OFS_VALUE_LOW);
    check(got, 8'hF0);
    wr_reg(tccu_pkg::OFS_PORT_DIR, 8'h3B);
    wr_reg(tccu_pkg::OFS_IRQ_FLAGS, 8'h04);
    wr_reg(tccu_pkg::OFS_CONTROL, {4'h0, tccu_pkg::MODE_CAP_RISE});
    rd_reg(tccu_pkg::OFS_IRQ_FLAGS);
    check(got, 8'h04);
    check(8'(pin_oe), 8'h01);
    wr_reg(tccu_pkg::OFS_IRQ_FLAGS, 8'h04);
    timer_count <= 16'h3C5A;
    wr_reg(tccu_pkg::OFS_PORT_LATCH, 8'h04);
    wait_irq;
    rd_reg(tccu_pkg::OFS_VALUE_HIGH);
    check(got, 8'h3C);
  endtask : overwrite_and_port

  task automatic cmp_case(input logic [3:0] m, input logic exp);
    wr_reg(tccu_pkg::OFS_CONTROL, {4'h0, m});
    wr_reg(tccu_pkg::OFS_IRQ_FLAGS, 8'h04);
    for (int k = 0; k < 2; k++) begin
      @(posedge clock);
      timer_count <= 16'h1233 + 16'(k);
      timer_tick  <= 1'b1;
      @(posedge clock);
      timer_tick <= 1'b0;
      repeat (3) @(posedge clock);
      #1 check(8'(irq), 8'(k));
    end
    check(8'(pin_out), 8'(exp));
  endtask : cmp_case

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial begin
    {resetn, addr, wdata, wr, rd, timer_count, timer_tick, ext_level} = '0;
    miscompares = 0;
    n_checks = 0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    rd_reg(tccu_pkg::OFS_PORT_DIR);
    check(got, 8'h3F);
    @(posedge clock);
    #1 check(rdata, 8'h00);
    rd_reg(tccu_pkg::OFS_IRQ_ENABLES);
    check(got, 8'h00);
    rd_reg(8'h18);
    check(got, 8'h00);
    check(8'(pin_oe), 8'h00);
    wr_reg(tccu_pkg::OFS_IRQ_ENABLES, 8'h04);
    capture_cycle(tccu_pkg::MODE_CAP_RISE, 16'hA5C3, 1);
    flag_clear;
    capture_cycle(tccu_pkg::MODE_CAP_RISE4, 16'h5AC3, 4);
    capture_cycle(tccu_pkg::MODE_CAP_RISE16, 16'hC35A, 16);
    overwrite_and_port;
    wr_reg(tccu_pkg::OFS_CONTROL, 8'h00);
    wr_reg(tccu_pkg::OFS_VALUE_LOW, 8'h34);
    wr_reg(tccu_pkg::OFS_VALUE_HIGH, 8'h12);
    cmp_case(tccu_pkg::MODE_CMP_HIGH, 1'b1);
    cmp_case(tccu_pkg::MODE_CMP_LOW, 1'b0);
    cmp_case(tccu_pkg::MODE_CMP_IRQ, 1'b0);
    cmp_case(tccu_pkg::MODE_CMP_HIGH, 1'b1);
    wr_reg(tccu_pkg::OFS_CONTROL, 8'h00);
    wr_reg(tccu_pkg::OFS_CONTROL, {4'h0, tccu_pkg::MODE_CMP_EVENT});
    repeat (2) @(posedge clock);
    #1 check(8'(pin_out), 8'h00);
    end_of_test;
  end
endmodule : timer_capture_compare_unit_bench
